// ---- rtl/fcs_top.sv ----
// Function
// - Commands act only while enable field is 0011B
// - Writing 1100B disables command execution
// - Reset loads enable field with 1100B
// - Control register low nibble reads 0
// - Decode low 12 bits except targets and the full 16-bit FF7FH security cycle
// - Six unlock-prefixed commands, single F0 exit
// - Program starts on fourth write cycle
// - Erase six cycles, 30H sector, 10H chip
// - Flash occupies C000H to FFFFH
// - Parallel programmer mode bypasses sequencer
// - Busy reads toggle bit 6, first 1
// - No new command while operation busy
// - No flash reads served while busy
`timescale 1ns/10ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_top
	import fcs_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB register port
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Processor memory bus
	input wire logic MEM_WR,
	input wire logic MEM_RD,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [7:0] MEM_WDATA,
	output logic [7:0] MEM_RDATA,
	output logic MEM_RVALID,
	// Flash macro side
	input wire logic PAR_MODE,
	input wire logic [7:0] ARR_RDATA,
	input wire logic ARR_DONE,
	output logic ARR_RD,
	output logic CMD_VALID,
	output fcs_cmd_t CMD,
	output logic ID_MODE,
	output logic BUSY
);
	logic [3:0] en_r;
	fcs_state_t st_r, st_nxt;
	logic busy_r, busy_nxt;
	logic id_r, id_nxt;
	logic tog_r, tog_nxt;
	logic cv_r, cv_nxt;
	fcs_cmd_t cmd_r, cmd_nxt;
	logic [7:0] rd_r;
	logic rv_r;
	logic [31:0] prdata_r;
	logic slverr_r;

	// Address and data match of one command cycle
	function automatic logic hit(input logic [15:0] a, input logic [7:0] d,
		input logic [11:0] ea, input logic [7:0] ed);
		hit = (a[`FCS_LOW_MSB:0] == ea) && (d == ed);
	endfunction

	wire in_win = MEM_ADDR[`FCS_WIN_MSB:`FCS_WIN_LSB] == `FCS_WIN_TOP;
	wire armed = en_r == `FCS_EN_ON;
	wire take = MEM_WR && in_win && armed && !PAR_MODE && !busy_r;
	wire w_aa = hit(MEM_ADDR, MEM_WDATA, `FCS_A_555, `FCS_D_AA);
	wire w_55 = hit(MEM_ADDR, MEM_WDATA, `FCS_A_AAA, `FCS_D_55);
	wire w_exit1 = MEM_WDATA == `FCS_D_IDOUT;
	wire w_chip = hit(MEM_ADDR, MEM_WDATA, `FCS_A_555, `FCS_D_CHIP);
	wire w_sect = MEM_WDATA == `FCS_D_SECT;
	wire w_sec = MEM_ADDR == `FCS_A_SEC && MEM_WDATA == `FCS_D_SECVAL;
	wire w_code = MEM_ADDR[`FCS_LOW_MSB:0] == `FCS_A_555;
	wire rd_ok = MEM_RD && in_win && !busy_r;

	wire apb_acc = PSEL && PENABLE;
	wire a_ctrl = PADDR == `FCS_OFS_CTRL;
	wire a_stat = PADDR == `FCS_OFS_STAT;
	wire apb_bad = !(a_ctrl || a_stat);
	wire ctrl_we = apb_acc && PWRITE && a_ctrl;

	// Command decoder
	always_comb begin
		st_nxt = st_r;
		id_nxt = id_r;
		cv_nxt = 1'b0;
		cmd_nxt = cmd_r;
		if (take) begin
			st_nxt = w_aa ? FCS_S_U1 : FCS_S_IDLE;
			if (w_exit1 && !(st_r == FCS_S_U2)) begin
				id_nxt = 1'b0;
			end
			unique case (st_r)
				FCS_S_IDLE: begin
				end
				FCS_S_U1: begin
					if (w_55) begin
						st_nxt = FCS_S_U2;
					end
				end
				FCS_S_U2: begin
					if (w_code) begin
						unique case (MEM_WDATA)
							`FCS_D_PROG: st_nxt = FCS_S_PROG;
							`FCS_D_ERASE: st_nxt = FCS_S_E1;
							`FCS_D_SEC: st_nxt = FCS_S_SEC;
							`FCS_D_IDIN: begin
								st_nxt = FCS_S_IDLE;
								id_nxt = 1'b1;
							end
							`FCS_D_IDOUT: begin
								st_nxt = FCS_S_IDLE;
								id_nxt = 1'b0;
							end
							default: st_nxt = FCS_S_IDLE;
						endcase
					end
				end
				FCS_S_PROG: begin
					st_nxt = FCS_S_IDLE;
					cv_nxt = 1'b1;
					cmd_nxt = '{FCS_OP_PROG, MEM_ADDR, MEM_WDATA};
				end
				FCS_S_E1: begin
					if (w_aa) begin
						st_nxt = FCS_S_E2;
					end
				end
				FCS_S_E2: begin
					st_nxt = w_55 ? FCS_S_E3 : st_nxt;
				end
				FCS_S_E3: begin
					st_nxt = FCS_S_IDLE;
					if (w_chip) begin
						cv_nxt = 1'b1;
						cmd_nxt = '{FCS_OP_CHIP, MEM_ADDR, MEM_WDATA};
					end else if (w_sect) begin
						cv_nxt = 1'b1;
						cmd_nxt = '{FCS_OP_SECT, MEM_ADDR & `FCS_SECT_MASK, MEM_WDATA};
					end
				end
				FCS_S_SEC: begin
					st_nxt = FCS_S_IDLE;
					if (w_sec) begin
						cv_nxt = 1'b1;
						cmd_nxt = '{FCS_OP_SEC, MEM_ADDR, MEM_WDATA};
					end
				end
			endcase
		end
	end

	// Busy tracking and toggle bit
	always_comb begin
		busy_nxt = busy_r;
		tog_nxt = tog_r;
		if (cv_nxt) begin
			busy_nxt = 1'b1;
			tog_nxt = 1'b1;
		end else if (busy_r && ARR_DONE) begin
			busy_nxt = 1'b0;
		end else if (busy_r && MEM_RD && in_win) begin
			tog_nxt = !tog_r;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_r <= FCS_S_IDLE;
			busy_r <= 1'b0;
			id_r <= 1'b0;
			tog_r <= 1'b1;
			cv_r <= 1'b0;
			cmd_r <= '0;
		end else begin
			st_r <= st_nxt;
			busy_r <= busy_nxt;
			id_r <= id_nxt;
			tog_r <= tog_nxt;
			cv_r <= cv_nxt;
			cmd_r <= cmd_nxt;
		end
	end

	// Read data path
	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_r <= 8'h00;
			rv_r <= 1'b0;
		end else begin
			rv_r <= MEM_RD && in_win;
			rd_r <= busy_r ? (8'h00 | ({7'h00, tog_r} << `FCS_TOG_BIT)) : ARR_RDATA;
		end
	end

	// APB registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			en_r <= `FCS_EN_OFF;
			prdata_r <= 32'h0;
			slverr_r <= 1'b0;
		end else begin
			if (ctrl_we) begin
				en_r <= PWDATA[`FCS_EN_MSB:`FCS_EN_LSB];
			end
			slverr_r <= PSEL && !PENABLE && apb_bad;
			if (PSEL && !PENABLE) begin
				prdata_r <= 32'h0;
				if (a_ctrl) begin
					prdata_r[`FCS_EN_MSB:`FCS_EN_LSB] <= en_r;
				end
				if (a_stat) begin
					prdata_r[`FCS_BUSY_BIT] <= busy_r;
					prdata_r[`FCS_ID_BIT] <= id_r;
				end
			end
		end
	end

	assign PRDATA = prdata_r;
	assign PREADY = 1'b1;
	assign PSLVERR = apb_acc && slverr_r;
	assign MEM_RDATA = rd_r;
	assign MEM_RVALID = rv_r;
	assign ARR_RD = rd_ok;
	assign CMD_VALID = cv_r;
	assign CMD = cmd_r;
	assign ID_MODE = id_r;
	assign BUSY = busy_r;

	sequence s_unlock;
		st_r == FCS_S_U1 && take && w_55;
	endsequence

	sequence s_prog_cycle;
		st_r == FCS_S_PROG && take;
	endsequence

	sequence s_prog_start;
		CMD_VALID && CMD.op == FCS_OP_PROG
		&& CMD.addr == $past(MEM_ADDR) && CMD.data == $past(MEM_WDATA);
	endsequence

	a_disarm_noop: assert property (@(posedge CLK) disable iff (RST)
		!armed |=> !CMD_VALID)
		else $error("command issued while disarmed");
	a_disable_code: assert property (@(posedge CLK) disable iff (RST)
		ctrl_we && PWDATA[`FCS_EN_MSB:`FCS_EN_LSB] == `FCS_EN_OFF |=> !armed)
		else $error("disable code did not disarm");
	a_reset_off: assert property (@(posedge CLK)
		RST |=> en_r == `FCS_EN_OFF)
		else $error("enable field not off after reset");
	a_unlock_step: assert property (@(posedge CLK) disable iff (RST)
		s_unlock |=> st_r == FCS_S_U2)
		else $error("unlock pair did not advance");
	a_prog_fourth: assert property (@(posedge CLK) disable iff (RST)
		s_prog_cycle |=> s_prog_start)
		else $error("program not started on fourth cycle");
	a_chip_sixth: assert property (@(posedge CLK) disable iff (RST)
		st_r == FCS_S_E3 && take && w_chip |=> CMD_VALID && CMD.op == FCS_OP_CHIP)
		else $error("chip erase not started");
	a_sect_sixth: assert property (@(posedge CLK) disable iff (RST)
		st_r == FCS_S_E3 && take && w_sect |=> CMD_VALID && CMD.op == FCS_OP_SECT
		&& CMD.addr == ($past(MEM_ADDR) & `FCS_SECT_MASK))
		else $error("sector erase not started");
	a_sec_final: assert property (@(posedge CLK) disable iff (RST)
		st_r == FCS_S_SEC && take && w_sec |=> CMD_VALID && CMD.op == FCS_OP_SEC)
		else $error("security program not started");
	a_busy_block: assert property (@(posedge CLK) disable iff (RST)
		busy_r && !ARR_DONE |=> !CMD_VALID)
		else $error("command accepted while busy");
	a_no_read_busy: assert property (@(posedge CLK) disable iff (RST)
		busy_r |-> !ARR_RD)
		else $error("array read while busy");
	a_toggle_first: assert property (@(posedge CLK) disable iff (RST)
		CMD_VALID && MEM_RD && in_win && !ARR_DONE |=> MEM_RDATA[6])
		else $error("first busy read bit 6 not one");
	a_bad_idle: assert property (@(posedge CLK) disable iff (RST)
		st_r == FCS_S_U1 && take && !w_55 && !w_aa |=> st_r == FCS_S_IDLE)
		else $error("mismatch did not return to idle");
	a_par_bypass: assert property (@(posedge CLK) disable iff (RST)
		PAR_MODE |=> !CMD_VALID)
		else $error("command issued in parallel mode");
	a_window_only: assert property (@(posedge CLK) disable iff (RST)
		MEM_WR && !in_win |-> !take)
		else $error("write outside flash window taken");
	a_id_exit: assert property (@(posedge CLK) disable iff (RST)
		take && w_exit1 && st_r != FCS_S_U2 |=> !ID_MODE)
		else $error("single exit write kept id mode");
	a_idle_read: assert property (@(posedge CLK) disable iff (RST)
		MEM_RD && in_win && !busy_r |=> MEM_RVALID && MEM_RDATA == $past(ARR_RDATA))
		else $error("idle read did not return array data");
	a_busy_hold: assert property (@(posedge CLK) disable iff (RST)
		busy_r && !ARR_DONE |=> BUSY)
		else $error("busy dropped before operation done");
endmodule
`default_nettype wire

// ---- rtl/fcs_defines.svh ----
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// Command enable field codes
`define FCS_EN_ON 4'h3
`define FCS_EN_OFF 4'hc
`define FCS_EN_MSB 7
`define FCS_EN_LSB 4
// Register byte offsets
`define FCS_OFS_CTRL 12'h000
`define FCS_OFS_STAT 12'h004
// Command cycle addresses and data
`define FCS_A_555 12'h555
`define FCS_A_AAA 12'haaa
`define FCS_A_SEC 16'hff7f
`define FCS_D_AA 8'haa
`define FCS_D_55 8'h55
`define FCS_D_PROG 8'ha0
`define FCS_D_ERASE 8'h80
`define FCS_D_IDIN 8'h90
`define FCS_D_IDOUT 8'hf0
`define FCS_D_SEC 8'ha5
`define FCS_D_SECT 8'h30
`define FCS_D_CHIP 8'h10
`define FCS_D_SECVAL 8'h00
// Flash window C000H..FFFFH: top two address bits set
`define FCS_WIN_TOP 2'b11
`define FCS_WIN_MSB 15
`define FCS_WIN_LSB 14
`define FCS_LOW_MSB 11
`define FCS_SECT_MASK 16'hf000
`define FCS_TOG_BIT 6
`define FCS_BUSY_BIT 0
`define FCS_ID_BIT 1
`endif

// ---- rtl/fcs_pkg.sv ----
package fcs_pkg;
	typedef enum logic [1:0] {
		FCS_OP_PROG = 2'h0,
		FCS_OP_SECT = 2'h1,
		FCS_OP_CHIP = 2'h2,
		FCS_OP_SEC = 2'h3
	} fcs_op_t;
	typedef struct packed {
		fcs_op_t op;
		logic [15:0] addr;
		logic [7:0] data;
	} fcs_cmd_t;
	typedef enum logic [7:0] {
		FCS_S_IDLE = 8'h01,
		FCS_S_U1 = 8'h02,
		FCS_S_U2 = 8'h04,
		FCS_S_PROG = 8'h08,
		FCS_S_E1 = 8'h10,
		FCS_S_E2 = 8'h20,
		FCS_S_E3 = 8'h40,
		FCS_S_SEC = 8'h80
	} fcs_state_t;
endpackage

// ---- sim/fcs_arr_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module fcs_arr_model (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Sequencer side
	input wire logic CMD_VALID,
	input wire logic ARR_RD,
	output logic ARR_DONE,
	output logic [7:0] ARR_RDATA
);
	logic [7:0] cnt_r;
	logic [7:0] cyc_r;
	// Array data only while read, else a changing pattern
	assign ARR_RDATA = ARR_RD ? 8'h5a : cyc_r;
	always_ff @(posedge CLK) begin
		cyc_r <= cyc_r + 8'h01;
		ARR_DONE <= (cnt_r == 8'h01);
		if (RST) begin
			cnt_r <= 8'h00;
			cyc_r <= 8'h00;
			ARR_DONE <= 1'b0;
		end else if (CMD_VALID) begin
			cnt_r <= 8'h28;
		end else if (cnt_r != 8'h00) begin
			cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import fcs_pkg::*;
	logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MEM_WR = 0, MEM_RD = 0, PAR_MODE = 0;
	logic [11:0] PADDR = 0;
	logic [31:0] PWDATA = 0, PRDATA, r;
	logic PREADY, PSLVERR, MEM_RVALID, ARR_RD, ARR_DONE, CMD_VALID, ID_MODE, BUSY, e;
	logic [15:0] MEM_ADDR = 0, a;
	logic [7:0] MEM_WDATA = 0, MEM_RDATA, ARR_RDATA, d;
	fcs_cmd_t CMD, ec;
	logic [25:0] em;
	fcs_cmd_t eq[$];
	logic [25:0] mq[$];
	int failures = 0, checked = 0, n;
	always #12.5 CLK = ~CLK;
	fcs_top fcs_top_inst (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID),
		.PAR_MODE(PAR_MODE), .ARR_RDATA(ARR_RDATA), .ARR_DONE(ARR_DONE), .ARR_RD(ARR_RD),
		.CMD_VALID(CMD_VALID), .CMD(CMD), .ID_MODE(ID_MODE), .BUSY(BUSY));
	fcs_arr_model fcs_arr_model_inst (.CLK(CLK), .RST(RST), .CMD_VALID(CMD_VALID),
		.ARR_RD(ARR_RD), .ARR_DONE(ARR_DONE), .ARR_RDATA(ARR_RDATA));
	task chk(input bit ok, input string m);
		checked++;
		if (!ok) begin
			failures++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task stop_test;
		if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge CLK);
		PSEL <= 1; PWRITE <= w; PADDR <= ad; PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 0; PENABLE <= 0;
	endtask
	task mw(input logic [15:0] ad, input logic [7:0] wd);
		@(posedge CLK);
		MEM_WR <= 1; MEM_ADDR <= ad; MEM_WDATA <= wd;
		@(posedge CLK);
		MEM_WR <= 0;
	endtask
	task mr(input logic [15:0] ad, input bit lead, input bit bz, input logic [7:0] ex);
		if (lead) @(posedge CLK);
		MEM_RD <= 1;
		MEM_ADDR <= ad;
		#1 chk(ARR_RD === !bz, "array read");
		@(posedge CLK);
		MEM_RD <= 0;
		#1 chk(MEM_RVALID === 1'b1 && MEM_RDATA === ex, "read data");
	endtask
	task seq(input int k, input logic [15:0] ad, input logic [7:0] wd);
		logic [7:0] cd[6];
		logic [15:0] u;
		cd = '{8'ha0, 8'h80, 8'h80, 8'ha5, 8'h90, 8'hf0};
		u = {2'b11, 2'($urandom), 12'h000};
		mw(u | 16'h0555, 8'haa);
		mw(u | 16'h0aaa, 8'h55);
		mw(u | 16'h0555, cd[k]);
		if (k == 1 || k == 2) begin
			mw(16'hc555, 8'haa);
			mw(16'hcaaa, 8'h55);
		end
		if (k == 0) mw(ad, wd);
		if (k == 1) mw(ad, 8'h30);
		if (k == 2) mw(16'hc555, 8'h10);
		if (k == 3) mw(16'hff7f, 8'h00);
	endtask
	task wait_idle;
		n = 0;
		while (BUSY !== 1'b0 && n < 200) begin
			@(posedge CLK);
			n++;
		end
		chk(BUSY === 1'b0, "stuck busy");
	endtask
	always @(negedge CLK) if (CMD_VALID === 1'b1) begin
		if (eq.size() == 0) chk(0, "unexpected command");
		else begin
			ec = eq.pop_front();
			em = mq.pop_front();
			chk(((CMD ^ ec) & em) === 26'h0, "command fields");
		end
	end
	initial begin
		#(25 * 20000);
		failures++;
		stop_test;
	end
	initial begin
		r = $urandom(32'hc42bcb9c);
		repeat (10) @(posedge CLK);
		RST <= 0;
		apb(0, 12'h000, 0);
		chk(r[7:4] === 4'hc, "reset enable");
		apb(0, 12'h008, 0);
		chk(e === 1'b1, "unmapped");
		seq(0, 16'hc123, 8'h11);
		@(posedge CLK);
		chk(BUSY === 1'b0, "disarmed");
		apb(1, 12'h000, 32'h30);
		PAR_MODE <= 1;
		seq(0, 16'hc123, 8'h11);
		PAR_MODE <= 0;
		@(posedge CLK);
		chk(BUSY === 1'b0, "parallel");
		mw(16'h3555, 8'haa);
		mw(16'h3aaa, 8'h55);
		mw(16'h3555, 8'ha0);
		mw(16'h3abc, 8'h11);
		@(posedge CLK);
		chk(BUSY === 1'b0, "outside window");
		for (int k = 0; k < 4; k++) begin
			a = {2'b11, 14'($urandom)};
			d = 8'($urandom);
			eq.push_back({fcs_op_t'(k), (k == 1) ? {a[15:12], 12'h000} : a, d});
			mq.push_back(k == 0 ? '1 : (k == 1 ? 26'h3ffff00 : 26'h3000000));
			seq(k, a, d);
			for (int i = 0; i < 3; i++) begin
				mr(a, i > 0, 1'b1, {1'b0, i % 2 == 0, 6'h0});
			end
			chk(BUSY === 1'b1, "busy");
			apb(0, 12'h004, 0);
			chk(r[1:0] === 2'b01, "status busy");
			seq(0, a, d);
			wait_idle;
		end
		mr({2'b11, 14'($urandom)}, 1'b1, 1'b0, 8'h5a);
		mw(16'hc555, 8'haa);
		mw(16'hcaaa, 8'h54);
		mw(16'hc555, 8'ha0);
		mw(16'hc100, 8'h22);
		@(posedge CLK);
		chk(BUSY === 1'b0, "mismatch kept");
		seq(4, 0, 0);
		@(posedge CLK);
		chk(ID_MODE === 1'b1, "id entry");
		apb(0, 12'h004, 0);
		chk(r[1:0] === 2'b10, "status id");
		mw({2'b11, 14'($urandom)}, 8'hf0);
		@(posedge CLK);
		chk(ID_MODE === 1'b0, "id exit single");
		seq(4, 0, 0);
		seq(5, 0, 0);
		@(posedge CLK);
		chk(ID_MODE === 1'b0, "id exit long");
		apb(1, 12'h000, 32'hc0);
		apb(0, 12'h000, 0);
		chk(r[7:4] === 4'hc && e === 1'b0, "disarm readback");
		seq(0, 16'hc123, 8'h11);
		repeat (2) @(posedge CLK);
		chk(BUSY === 1'b0 && eq.size() == 0, "disarmed again");
		stop_test;
	end
endmodule
`default_nettype wire
